/* File: amrc_device.sv */
// Our own choice: the Avalon-MM register port.
module amrc_device
  import amrc_pkg::*;
#(
  parameter int unsigned P_CYC_PER_US = CYC_PER_US
) (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Link to the host
  amrc_link_if.dev_mp lnk,
  // Measurement front end
  input wire logic [5:0] i_meas_x,
  input wire logic [5:0] i_meas_y,
  input wire logic [5:0] i_meas_z,
  input wire logic i_shake,
  // Status toward the system
  output logic o_sample_tick,
  output logic [7:0] o_tilt
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  logic [7:0] op_ctrl_reg; // Operating control
  logic [7:0] rate_cfg_reg; // Sample rate configuration
  logic [7:0] sleep_limit_reg; // Sleep count limit
  logic [7:0] tap_cfg_reg; // Tap threshold register
  logic [5:0] x_reg, y_reg, z_reg; // Axis outputs
  logic [5:0] sx_reg, sy_reg, sz_reg; // Slow tap filters
  logic [7:0] tilt_reg; // Orientation status
  logic [1:0] cand_reg; // Debounce candidate
  logic [2:0] deb_cnt_reg; // Debounce match count
  logic ack_reg; // Link answer
  logic [7:0] rdata_reg; // Link read data
  logic irq_pend_reg; // Interrupt pending
  logic irq_drv_reg, irq_oe_n_reg; // Pin drive
  logic [31:0] smp_cnt_reg; // Sample period counter
  logic [31:0] tap_cnt_reg; // Tap refresh counter
  logic [3:0] pre_cnt_reg; // Sleep prescaler
  logic [7:0] sleep_cnt_reg; // Sleep counter
  logic smp_tick_reg; // Sample strobe
  amrc_rate_state_t state_reg, state_next;
  logic take, wr, rd, restart, running, use_wake, test_on;
  logic sleep_clk, timeout, tap_tick, tap_hit, axis_load, test_load;
  logic tilt_event, shake_ev, event_any;
  logic [31:0] period;
  logic [1:0] bafro_new;

  // ----------------------------------------
  // Link decode
  // ----------------------------------------
  assign take = lnk.req & ~ack_reg;
  assign wr = take & lnk.we;
  assign rd = take & ~lnk.we;
  // Any control access, or a sleep-count write, restarts sleep timing
  assign restart = (take & (lnk.addr == OFS_OP_CTRL)) | (wr & (lnk.addr == OFS_SLEEP_COUNT));
  assign test_on = op_ctrl_reg[BIT_TEST];
  assign running = (state_reg == RS_ACTIVE) | (state_reg == RS_SLEEP_RUN) | (state_reg == RS_WAKE);
  assign use_wake = (state_reg == RS_WAKE);

  // Sample period from the rate fields
  always_comb begin
    if (use_wake) begin
      case (rate_cfg_reg[WAKE_RATE_FIELD_LSB +: 2])
        2'h0: period = T_AM2_US * P_CYC_PER_US;
        2'h1: period = T_AM3_US * P_CYC_PER_US;
        2'h2: period = T_AM4_US * P_CYC_PER_US;
        default: period = T_AM7_US * P_CYC_PER_US;
      endcase
    end else begin
      case (rate_cfg_reg[ACTIVE_RATE_FIELD_LSB +: 3])
        3'h0: period = T_AM0_US * P_CYC_PER_US;
        3'h1: period = T_AM1_US * P_CYC_PER_US;
        3'h2: period = T_AM2_US * P_CYC_PER_US;
        3'h3: period = T_AM3_US * P_CYC_PER_US;
        3'h4: period = T_AM4_US * P_CYC_PER_US;
        3'h5: period = T_AM5_US * P_CYC_PER_US;
        3'h6: period = T_AM6_US * P_CYC_PER_US;
        default: period = T_AM7_US * P_CYC_PER_US;
      endcase
    end
  end

  // ----------------------------------------
  // Operating state
  // ----------------------------------------
  assign sleep_clk = smp_tick_reg & (state_reg == RS_SLEEP_RUN) &
                     (~op_ctrl_reg[BIT_SLEEP_PRESCALE_SELECT] | (pre_cnt_reg == PRESCALE_LAST));
  // A control access in the same cycle restarts timing, so it must not also time out
  assign timeout = sleep_clk & ~restart & (8'(sleep_cnt_reg + 8'h01) == sleep_limit_reg);

  // Next operating state
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      RS_STANDBY, RS_TEST: begin
        if (op_ctrl_reg[BIT_RUN]) begin
          state_next = op_ctrl_reg[BIT_ASE] ? RS_SLEEP_RUN : RS_ACTIVE;
        end else begin
          state_next = test_on ? RS_TEST : RS_STANDBY;
        end
      end
      RS_ACTIVE: begin
        if (!op_ctrl_reg[BIT_RUN]) state_next = test_on ? RS_TEST : RS_STANDBY;
      end
      RS_SLEEP_RUN: begin
        if (!op_ctrl_reg[BIT_RUN]) state_next = RS_STANDBY;
        else if (timeout) state_next = RS_WAKE;
      end
      RS_WAKE: begin
        if (!op_ctrl_reg[BIT_RUN]) begin
          state_next = RS_STANDBY;
        end else if (op_ctrl_reg[BIT_AWE] & event_any) begin
          state_next = op_ctrl_reg[BIT_ASE] ? RS_SLEEP_RUN : RS_ACTIVE;
        end
      end
      default: state_next = RS_STANDBY;
    endcase
  end

  // State register
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) state_reg <= RS_STANDBY;
    else state_reg <= state_next;
  end

  // ----------------------------------------
  // Timebases
  // ----------------------------------------
  // Sample period counter, restarted on any operating state change
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      smp_cnt_reg <= '0;
      smp_tick_reg <= 1'b0;
    end else if (!running || state_next != state_reg) begin
      smp_cnt_reg <= '0;
      smp_tick_reg <= 1'b0;
    end else if (smp_cnt_reg + 32'h1 >= period) begin
      smp_cnt_reg <= '0;
      smp_tick_reg <= 1'b1;
    end else begin
      smp_cnt_reg <= smp_cnt_reg + 32'h1;
      smp_tick_reg <= 1'b0;
    end
  end

  // Sleep prescaler and counter
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      pre_cnt_reg <= '0;
      sleep_cnt_reg <= '0;
    end else if (restart || state_reg != RS_SLEEP_RUN) begin
      pre_cnt_reg <= '0;
      sleep_cnt_reg <= '0;
    end else if (smp_tick_reg) begin
      pre_cnt_reg <= pre_cnt_reg + 4'h1;
      if (sleep_clk) sleep_cnt_reg <= sleep_cnt_reg + 8'h01;
    end
  end

  // Tap refresh every 260 us at the tap rate code
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) tap_cnt_reg <= '0;
    else if (!running || use_wake || tap_tick) tap_cnt_reg <= '0;
    else tap_cnt_reg <= tap_cnt_reg + 32'h1;
  end
  assign tap_tick = running & ~use_wake & (rate_cfg_reg[ACTIVE_RATE_FIELD_LSB +: 3] == TAP_RATE_CODE) &
                    (tap_cnt_reg + 32'h1 >= TAP_REFRESH_US * P_CYC_PER_US);

  // Fast value is the live reading, slow is a rolling average kept in offset binary
  function automatic logic over_thr(input logic [5:0] f, input logic [5:0] s, input logic [4:0] t);
    logic [5:0] fo;
    logic [5:0] d;
    fo = {~f[5], f[4:0]}; // Signed reading to offset binary keeps order across zero
    d = (fo >= s) ? 6'(fo - s) : 6'(s - fo);
    return d > {1'b0, t};
  endfunction
  assign tap_hit = tap_tick & (over_thr(i_meas_x, sx_reg, tap_cfg_reg[4:0]) |
                   over_thr(i_meas_y, sy_reg, tap_cfg_reg[4:0]) |
                   over_thr(i_meas_z, sz_reg, tap_cfg_reg[4:0]));

  // Slow filters
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      sx_reg <= '0;
      sy_reg <= '0;
      sz_reg <= '0;
    end else if (tap_tick) begin
      sx_reg <= 6'(({1'b0, sx_reg} + {1'b0, ~i_meas_x[5], i_meas_x[4:0]}) >> 1);
      sy_reg <= 6'(({1'b0, sy_reg} + {1'b0, ~i_meas_y[5], i_meas_y[4:0]}) >> 1);
      sz_reg <= 6'(({1'b0, sz_reg} + {1'b0, ~i_meas_z[5], i_meas_z[4:0]}) >> 1);
    end
  end

  // ----------------------------------------
  // Registers written over the link
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      op_ctrl_reg <= RST_OP_CTRL;
      rate_cfg_reg <= RST_RATE_CFG;
      sleep_limit_reg <= RST_BYTE;
      tap_cfg_reg <= RST_BYTE;
    end else if (wr) begin
      case (lnk.addr)
        OFS_OP_CTRL: op_ctrl_reg <= lnk.wdata & ~(8'h01 << BIT_UNUSED);
        OFS_RATE_CFG: rate_cfg_reg <= lnk.wdata;
        OFS_SLEEP_COUNT: sleep_limit_reg <= lnk.wdata;
        OFS_TAP_CFG: tap_cfg_reg <= lnk.wdata;
        default: ;
      endcase
    end
  end

  // Axis outputs: measurements when running, host data in test mode
  assign axis_load = smp_tick_reg & ~test_on;
  assign test_load = wr & (state_reg == RS_TEST) & (lnk.addr <= OFS_Z_AXIS);
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      x_reg <= '0;
      y_reg <= '0;
      z_reg <= '0;
    end else if (wr && lnk.addr == OFS_OP_CTRL) begin
      x_reg <= '0;
      y_reg <= '0;
      z_reg <= '0;
    end else if (axis_load) begin
      x_reg <= i_meas_x;
      y_reg <= i_meas_y;
      z_reg <= i_meas_z;
    end else if (test_load) begin
      if (lnk.addr == OFS_X_AXIS) x_reg <= lnk.wdata[5:0];
      if (lnk.addr == OFS_Y_AXIS) y_reg <= lnk.wdata[5:0];
      if (lnk.addr == OFS_Z_AXIS) z_reg <= lnk.wdata[5:0];
    end
  end

  // ----------------------------------------
  // Orientation status
  // ----------------------------------------
  always_comb begin
    if (test_load && lnk.addr == OFS_Z_AXIS) bafro_new = lnk.wdata[5] ? BAFRO_BACK : BAFRO_FRONT;
    else bafro_new = i_meas_z[5] ? BAFRO_BACK : BAFRO_FRONT;
    if (test_load && lnk.addr == OFS_Z_AXIS && lnk.wdata[5:0] == 6'h00) bafro_new = BAFRO_UNKNOWN;
  end
  assign shake_ev = i_shake & ~test_on & axis_load;
  assign tilt_event = (axis_load | (test_load & (lnk.addr == OFS_Z_AXIS))) & (bafro_new != tilt_reg[1:0]) &
                      (test_on | (rate_cfg_reg[TILT_DEBOUNCE_FIELD_LSB +: 3] == 3'h0) |
                       (cand_reg == bafro_new && deb_cnt_reg >= rate_cfg_reg[TILT_DEBOUNCE_FIELD_LSB +: 3]));
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      tilt_reg <= RST_BYTE;
      cand_reg <= BAFRO_UNKNOWN;
      deb_cnt_reg <= '0;
    end else if (wr && lnk.addr == OFS_OP_CTRL) begin
      tilt_reg <= RST_BYTE;
      deb_cnt_reg <= '0;
    end else begin
      if (axis_load) begin
        cand_reg <= bafro_new;
        deb_cnt_reg <= (cand_reg == bafro_new && deb_cnt_reg != 3'h7) ? 3'(deb_cnt_reg + 3'h1) : 3'h1;
        tilt_reg[TILT_SHAKE] <= shake_ev;
      end
      if (tilt_event) tilt_reg[1:0] <= bafro_new;
      if (tap_tick) tilt_reg[TILT_TAP] <= tap_hit;
    end
  end

  // ----------------------------------------
  // Interrupt pin
  // ----------------------------------------
  assign event_any = tilt_event | tap_hit | shake_ev;
  // Pending until the next address acknowledge; a new event wins
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) irq_pend_reg <= 1'b0;
    else if (event_any) irq_pend_reg <= 1'b1;
    else if (lnk.start) irq_pend_reg <= 1'b0;
  end
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_drv_reg <= 1'b0;
      irq_oe_n_reg <= 1'b1;
    end else if (op_ctrl_reg[BIT_IPP]) begin
      irq_drv_reg <= irq_pend_reg ~^ op_ctrl_reg[BIT_IAH];
      irq_oe_n_reg <= 1'b0;
    end else begin
      irq_drv_reg <= 1'b0;
      irq_oe_n_reg <= irq_pend_reg ~^ op_ctrl_reg[BIT_IAH];
    end
  end

  // ----------------------------------------
  // Link answer
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ack_reg <= 1'b0;
      rdata_reg <= RST_BYTE;
    end else begin
      ack_reg <= take;
      if (rd) begin
        case (lnk.addr)
          OFS_X_AXIS: rdata_reg <= {2'h0, x_reg};
          OFS_Y_AXIS: rdata_reg <= {2'h0, y_reg};
          OFS_Z_AXIS: rdata_reg <= {2'h0, z_reg};
          OFS_TILT: rdata_reg <= tilt_reg;
          OFS_RATE_STATUS: rdata_reg <= {6'h00, use_wake,
                                         (state_reg == RS_ACTIVE) | (state_reg == RS_SLEEP_RUN)};
          OFS_SLEEP_COUNT: rdata_reg <= sleep_limit_reg;
          OFS_OP_CTRL: rdata_reg <= op_ctrl_reg;
          OFS_RATE_CFG: rdata_reg <= rate_cfg_reg;
          OFS_TAP_CFG: rdata_reg <= tap_cfg_reg;
          default: rdata_reg <= RST_BYTE;
        endcase
      end
    end
  end

  assign lnk.ack = ack_reg;
  assign lnk.rdata = rdata_reg;
  assign lnk.irq_drv = irq_drv_reg;
  assign lnk.irq_oe_n = irq_oe_n_reg;
  assign o_sample_tick = smp_tick_reg;
  assign o_tilt = tilt_reg;

endmodule

/* File: amrc_pkg.sv */
package amrc_pkg;

  // ----------------------------------------
  // Register offsets on the link
  // ----------------------------------------
  localparam logic [7:0] OFS_X_AXIS = 8'h00;
  localparam logic [7:0] OFS_Y_AXIS = 8'h01;
  localparam logic [7:0] OFS_Z_AXIS = 8'h02;
  localparam logic [7:0] OFS_TILT = 8'h03;
  localparam logic [7:0] OFS_RATE_STATUS = 8'h04;
  localparam logic [7:0] OFS_SLEEP_COUNT = 8'h05;
  localparam logic [7:0] OFS_OP_CTRL = 8'h07;
  localparam logic [7:0] OFS_RATE_CFG = 8'h08;
  localparam logic [7:0] OFS_TAP_CFG = 8'h09;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [7:0] RST_OP_CTRL = 8'h00;
  localparam logic [7:0] RST_RATE_CFG = 8'h00;
  localparam logic [7:0] RST_BYTE = 8'h00;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int BIT_RUN = 0;
  localparam int BIT_UNUSED = 1;
  localparam int BIT_TEST = 2;
  localparam int BIT_AWE = 3;
  localparam int BIT_ASE = 4;
  localparam int BIT_SLEEP_PRESCALE_SELECT = 5;
  localparam int BIT_IPP = 6;
  localparam int BIT_IAH = 7;
  localparam int ACTIVE_RATE_FIELD_LSB = 0;
  localparam int WAKE_RATE_FIELD_LSB = 3;
  localparam int TILT_DEBOUNCE_FIELD_LSB = 5;
  localparam int TILT_SHAKE = 7;
  localparam int TILT_TAP = 5;
  localparam logic [2:0] TAP_RATE_CODE = 3'h0;
  localparam logic [1:0] BAFRO_FRONT = 2'h1;
  localparam logic [1:0] BAFRO_BACK = 2'h2;
  localparam logic [1:0] BAFRO_UNKNOWN = 2'h0;

  // ----------------------------------------
  // Timing
  // ----------------------------------------
  localparam int unsigned CLK_PERIOD_NS = 4;
  localparam int unsigned NS_PER_US = 1000;
  localparam int unsigned CYC_PER_US = NS_PER_US / CLK_PERIOD_NS;
  localparam int unsigned TAP_REFRESH_US = 260;
  localparam int unsigned T_AM0_US = 8360;
  localparam int unsigned T_AM1_US = 15625;
  localparam int unsigned T_AM2_US = 31250;
  localparam int unsigned T_AM3_US = 62500;
  localparam int unsigned T_AM4_US = 125000;
  localparam int unsigned T_AM5_US = 250000;
  localparam int unsigned T_AM6_US = 500000;
  localparam int unsigned T_AM7_US = 1000000;
  localparam logic [3:0] PRESCALE_LAST = 4'hF;

  // ----------------------------------------
  // Host controller Avalon map
  // ----------------------------------------
  localparam logic [3:0] AVS_CMD = 4'h0;
  localparam logic [3:0] AVS_STATUS = 4'h4;
  localparam logic [3:0] AVS_RDATA = 4'h8;
  localparam int CMD_WRITE_BIT = 16;
  localparam int ST_BUSY = 0;
  localparam int ST_IRQ = 1;
  localparam int ST_REFUSED = 2;
  localparam int ST_DONE = 3;

  // Device operating states
  typedef enum logic [2:0] {
    RS_STANDBY,
    RS_TEST,
    RS_ACTIVE,
    RS_SLEEP_RUN,
    RS_WAKE
  } amrc_rate_state_t;

  // Host link sequencer states
  typedef enum logic [1:0] {
    HS_IDLE,
    HS_START,
    HS_REQ
  } amrc_host_state_t;

endpackage

/* File: amrc_link_if.sv */
interface amrc_link_if;
  // Transaction framing: start pulses at the address acknowledge
  logic start;
  logic req;
  logic we;
  logic [7:0] addr;
  logic [7:0] wdata;
  logic ack;
  logic [7:0] rdata;
  // Interrupt pin, two drive signals plus resolved wire with pull-up
  logic irq_drv;
  logic irq_oe_n;
  logic irq_wire;

  assign irq_wire = irq_oe_n ? 1'b1 : irq_drv;

  modport dev_mp(input start, req, we, addr, wdata, output ack, rdata, irq_drv, irq_oe_n);
  modport host_mp(output start, req, we, addr, wdata, input ack, rdata, irq_wire);
endinterface

/* File: amrc_host.sv */
module amrc_host
  import amrc_pkg::*;
(
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Avalon-MM slave
  input wire logic [3:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [31:0] i_avs_writedata,
  output logic [31:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  // Link to the device
  amrc_link_if.host_mp lnk,
  // Interrupt seen active
  output logic o_irq
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  amrc_host_state_t hs_reg; // Link sequencer
  logic [7:0] addr_reg, wdata_reg, rdata_reg; // Current transfer
  logic we_reg, start_reg, req_reg; // Link drive
  logic [7:0] shadow_reg; // Last control value written
  logic refused_reg, done_reg, rd_ack_reg; // Status and read answer
  logic [31:0] readdata_reg;
  logic irq_s1_reg, irq_s2_reg; // Pin synchroniser
  logic cmd_hit, cmd_take, bad, st_clr;
  logic [7:0] c_addr, c_data;

  // ----------------------------------------
  // Command decode and guard
  // ----------------------------------------
  assign cmd_hit = i_avs_write & (i_avs_address == AVS_CMD);
  assign o_avs_waitrequest = (cmd_hit & (hs_reg != HS_IDLE)) | (i_avs_read & ~rd_ack_reg);
  assign cmd_take = cmd_hit & (hs_reg == HS_IDLE);
  assign c_addr = i_avs_writedata[15:8];
  assign c_data = i_avs_writedata[7:0];
  assign st_clr = i_avs_write & (i_avs_address == AVS_STATUS) & i_avs_writedata[ST_REFUSED];
  // Writes that break the mode sequence are refused
  always_comb begin
    bad = 1'b0;
    if (i_avs_writedata[CMD_WRITE_BIT]) begin
      if (c_addr == OFS_OP_CTRL) begin
        if (c_data[BIT_RUN] && shadow_reg[BIT_TEST]) bad = 1'b1;
        if (c_data[BIT_TEST] && shadow_reg[BIT_RUN]) bad = 1'b1;
      end else if (c_addr > OFS_Z_AXIS && shadow_reg[BIT_RUN]) begin
        bad = 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Link sequencer
  // ----------------------------------------
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      hs_reg <= HS_IDLE;
      start_reg <= 1'b0;
      req_reg <= 1'b0;
      we_reg <= 1'b0;
      addr_reg <= '0;
      wdata_reg <= '0;
    end else begin
      case (hs_reg)
        HS_IDLE: begin
          if (cmd_take && !bad) begin
            addr_reg <= c_addr;
            wdata_reg <= c_data;
            we_reg <= i_avs_writedata[CMD_WRITE_BIT];
            start_reg <= 1'b1;
            hs_reg <= HS_START;
          end
        end
        HS_START: begin
          start_reg <= 1'b0;
          req_reg <= 1'b1;
          hs_reg <= HS_REQ;
        end
        HS_REQ: begin
          if (lnk.ack) begin
            req_reg <= 1'b0;
            hs_reg <= HS_IDLE;
          end
        end
        default: hs_reg <= HS_IDLE;
      endcase
    end
  end

  // Shadow of control, read data, status flags
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      shadow_reg <= RST_OP_CTRL;
      rdata_reg <= '0;
      done_reg <= 1'b0;
      refused_reg <= 1'b0;
    end else begin
      if (hs_reg == HS_REQ && lnk.ack) begin
        done_reg <= 1'b1;
        if (!we_reg) rdata_reg <= lnk.rdata;
        if (we_reg && addr_reg == OFS_OP_CTRL) shadow_reg <= wdata_reg & ~(8'h01 << BIT_UNUSED);
      end else if (cmd_take) begin
        done_reg <= 1'b0;
      end
      if (cmd_take && bad) refused_reg <= 1'b1;
      else if (st_clr) refused_reg <= 1'b0;
    end
  end

  // Interrupt pin through two flops
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      irq_s1_reg <= 1'b1;
      irq_s2_reg <= 1'b1;
    end else begin
      irq_s1_reg <= lnk.irq_wire;
      irq_s2_reg <= irq_s1_reg;
    end
  end
  assign o_irq = (irq_s2_reg == shadow_reg[BIT_IAH]);

  // Avalon read answer one cycle after the request
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      rd_ack_reg <= 1'b0;
      readdata_reg <= '0;
    end else begin
      rd_ack_reg <= i_avs_read & ~rd_ack_reg;
      case (i_avs_address)
        AVS_STATUS: readdata_reg <= {28'h0, done_reg, refused_reg, o_irq, hs_reg != HS_IDLE};
        AVS_RDATA: readdata_reg <= {24'h0, rdata_reg};
        default: readdata_reg <= '0;
      endcase
    end
  end

  assign o_avs_readdata = readdata_reg;
  assign lnk.start = start_reg;
  assign lnk.req = req_reg;
  assign lnk.we = we_reg;
  assign lnk.addr = addr_reg;
  assign lnk.wdata = wdata_reg;

endmodule

/* File: amrc_sva.sv */
module amrc_sva (
  // Clock and reset
  input wire logic i_ref_clk,
  input wire logic i_arst_n,
  // Link signals
  input wire logic start, req, we, ack, irq_drv, irq_oe_n, irq_wire,
  input wire logic [7:0] addr, wdata, rdata
);
  timeunit 1ns;
  timeprecision 100ps;
  // Control byte as last sent over the link
  logic [7:0] ctl_reg;
  always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
    if (!i_arst_n) begin
      ctl_reg <= 8'h00;
    end else if (ack && we && addr == 8'h07) begin
      ctl_reg <= wdata;
    end
  end
  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_arst_n);
  // Request taken, answered once, then dropped
  sequence s_walk;
    req && !ack ##1 ack ##1 !req;
  endsequence
  sequence s_not_ctl;
    start ##1 !(we && addr == 8'h07);
  endsequence
  a_xfer_walk: assert property (start |=> s_walk)
    else $error("link transfer walk broken");
  a_ack_pulse: assert property (ack |=> !ack)
    else $error("ack longer than one cycle");
  a_req_hold: assert property (req && !ack |=> req && $stable(addr) && $stable(we) && $stable(wdata))
    else $error("request changed before ack");
  a_unused_zero: assert property (ack && !we && addr == 8'h07 |-> !rdata[1])
    else $error("unused control bit read as one");
  a_open_drain: assert property (!ctl_reg[6] && !$past(ctl_reg[6]) && !irq_oe_n |-> !irq_drv)
    else $error("open drain pin driven high");
  a_push_pull: assert property (ctl_reg[6] && $past(ctl_reg[6], 2) |-> !irq_oe_n)
    else $error("push pull pin not driven");
  a_irq_release: assert property (s_not_ctl |-> ##1 irq_wire == !ctl_reg[7])
    else $error("interrupt not released after address");
endmodule

/* File: accel_mode_and_rate_control_tb.sv */
module accel_mode_and_rate_control_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, arst_n, av_rd, av_wr, tick, irq, shk;
  logic [7:0] tilt;
  logic [3:0] av_a;
  logic [31:0] av_wd, av_q;
  logic av_wait;
  logic [5:0] mx, my, mz;
  logic [15:0] seed = 16'hBD34;
  int num_errors = 0;
  int num_checks = 0;
  amrc_link_if lnk_i();
  amrc_device #(.P_CYC_PER_US(1)) amrc_device_i (.i_ref_clk(clk), .i_arst_n(arst_n), .lnk(lnk_i),
    .i_meas_x(mx), .i_meas_y(my), .i_meas_z(mz), .i_shake(shk), .o_sample_tick(tick), .o_tilt(tilt));
  amrc_host amrc_host_i (.i_ref_clk(clk), .i_arst_n(arst_n), .i_avs_address(av_a), .i_avs_read(av_rd),
    .i_avs_write(av_wr), .i_avs_writedata(av_wd), .o_avs_readdata(av_q), .o_avs_waitrequest(av_wait),
    .lnk(lnk_i), .o_irq(irq));
  amrc_sva amrc_sva_i (.i_ref_clk(clk), .i_arst_n(arst_n), .start(lnk_i.start), .req(lnk_i.req),
    .we(lnk_i.we), .ack(lnk_i.ack), .irq_drv(lnk_i.irq_drv), .irq_oe_n(lnk_i.irq_oe_n),
    .irq_wire(lnk_i.irq_wire), .addr(lnk_i.addr), .wdata(lnk_i.wdata), .rdata(lnk_i.rdata));
  // Free-running clock
  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  // Xorshift source of stimulus
  function automatic logic [7:0] rnd();
    seed ^= seed << 7;
    seed ^= seed >> 9;
    seed ^= seed << 8;
    return seed[7:0];
  endfunction
  // Control readback drops the unused bit
  function automatic logic [7:0] ctl_exp(input logic [7:0] v);
    return v & 8'hFD;
  endfunction
  // Front or back from the sign of z, unknown when z is zero
  function automatic logic [1:0] tilt_exp(input logic [7:0] z);
    return (z[5:0] == 6'h00) ? 2'h0 : (z[5] ? 2'h2 : 2'h1);
  endfunction
  task automatic chk(input string nm, input logic [7:0] e, input logic [7:0] g);
    num_checks++;
    if (g !== e) begin
      num_errors++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", num_checks, num_errors);
    if (num_errors == 0 && num_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // One Avalon cycle, held until waitrequest is seen low
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] q);
    av_a <= a;
    av_wd <= d;
    av_wr <= w;
    av_rd <= !w;
    @(posedge clk);
    while (av_wait !== 1'b0) @(posedge clk);
    q = av_q;
    av_wr <= 1'b0;
    av_rd <= 1'b0;
    @(posedge clk);
  endtask
  // One device register access through the host
  task automatic dev(input logic w, input logic [7:0] r, input logic [7:0] d, output logic [7:0] o);
    logic [31:0] q;
    av(1'b1, 4'h0, {15'h0, w, r, d}, q);
    q = 32'h1;
    while (q[0] !== 1'b0) av(1'b0, 4'h4, 32'h0, q);
    av(1'b0, 4'h8, 32'h0, q);
    o = q[7:0];
  endtask
  task automatic ticks(input int k);
    while (k > 0) begin
      @(posedge clk);
      if (tick === 1'b1) k--;
    end
  endtask
  initial begin
    #360000;
    num_errors++;
    report_and_stop();
  end
  initial begin
    logic [7:0] v, e, o;
    logic [31:0] q;
    arst_n = 1'b0;
    {av_rd, av_wr, av_a, av_wd} = '0;
    mx <= 6'(rnd());
    my <= 6'(rnd());
    mz <= 6'(rnd());
    shk <= 1'b0;
    repeat (8) @(posedge clk);
    arst_n <= 1'b1;
    @(posedge clk);
    dev(1'b0, 8'h07, 8'h00, o);
    chk("ctl", 8'h00, o);
    dev(1'b0, 8'h08, 8'h00, o);
    chk("rate", 8'h00, o);
    av(1'b0, 4'hC, 32'h0, q);
    chk("unmapped", 8'h00, q[7:0]);
    // Standby control values, pin type and level
    for (int i = 0; i < 6; i++) begin
      v = rnd() & 8'hFA;
      dev(1'b1, 8'h07, v, o);
      dev(1'b0, 8'h07, 8'h00, o);
      chk("ctl", ctl_exp(v), o);
      chk("pin", {7'h0, !v[7]}, {7'h0, lnk_i.irq_wire});
      chk("oe_n", {7'h0, !(v[6] || v[7])}, {7'h0, lnk_i.irq_oe_n});
    end
    $display("test standby done");
    // Test mode axis written by host, then cleared
    shk <= 1'b1;
    dev(1'b1, 8'h07, 8'h04, o);
    e = rnd() & 8'h3F;
    dev(1'b1, 8'h00, e, o);
    dev(1'b0, 8'h00, 8'h00, o);
    chk("x", e, o);
    // Host-written z drives front/back and the pin as in active mode
    e = rnd() & 8'h3F;
    dev(1'b1, 8'h02, e, o);
    chk("irq", {7'h0, tilt_exp(e) != 2'h0}, {7'h0, irq});
    dev(1'b0, 8'h03, 8'h00, o);
    chk("tilt", {6'h0, tilt_exp(e)}, o);
    chk("o_tilt", {6'h0, tilt_exp(e)}, tilt);
    chk("irq", 8'h00, {7'h0, irq});
    dev(1'b1, 8'h07, 8'h04, o);
    dev(1'b0, 8'h00, 8'h00, o);
    chk("x", 8'h00, o);
    dev(1'b1, 8'h07, 8'h05, o);
    av(1'b0, 4'h4, 32'h0, q);
    chk("refused", 8'h01, {7'h0, q[2]});
    av(1'b1, 4'h4, 32'h4, q);
    dev(1'b0, 8'h07, 8'h00, o);
    chk("ctl", 8'h04, o);
    $display("test mode done");
    // Auto-sleep timing at the fastest rate
    dev(1'b1, 8'h07, 8'h00, o);
    dev(1'b1, 8'h05, 8'h03, o);
    dev(1'b1, 8'h08, rnd() & 8'hF8, o);
    dev(1'b1, 8'h07, 8'h11, o);
    dev(1'b0, 8'h04, 8'h00, o);
    chk("rate_st", 8'h01, o);
    ticks(2);
    dev(1'b0, 8'h07, 8'h00, o);
    ticks(2);
    dev(1'b0, 8'h04, 8'h00, o);
    chk("rate_st", 8'h01, o);
    ticks(1);
    dev(1'b0, 8'h04, 8'h00, o);
    chk("rate_st", 8'h02, o);
    dev(1'b1, 8'h07, 8'h00, o);
    dev(1'b0, 8'h04, 8'h00, o);
    chk("rate_st", 8'h00, o);
    $display("test sleep done");
    report_and_stop();
  end
endmodule
